// file: dac_cfg_pkg.sv
// Constants shared by the DAC configuration and serial interface logic.
package dac_cfg_pkg;

  // Serial frame layout: read flag, five address bits, sixteen data bits.
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_CNT = 5'h18;
  localparam int RW_POS = 23;
  localparam int ADDR_MSB = 20;
  localparam int ADDR_LSB = 16;
  localparam int ADDR_W = 5;
  localparam int WORD_W = 16;
  localparam logic [7:0] PAD_ZERO = 8'h00;

  // Register addresses; bits 4:3 pick a channel bank, bits 2:0 a channel.
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_A = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_B = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_SPI_MODE = 5'h06;
  localparam logic [1:0] BANK_INPUT = 2'h1;
  localparam logic [1:0] BANK_ZERO = 2'h2;
  localparam logic [1:0] BANK_GAIN = 2'h3;

  // Configuration field positions.
  localparam int SRST_POS = 13;
  localparam int PDA_POS = 12;
  localparam int PDB_POS = 11;
  localparam int CAL_POS = 10;
  localparam int GAINA_POS = 8;
  localparam int GAINB_POS = 7;
  localparam int SDODIS_POS = 6;
  localparam int ALTW_POS = 4;
  localparam int SLEEP_POS = 15;

  // Stored bits and bits that read back (reserved, no-effect, reset: zero).
  localparam logic [WORD_W-1:0] CFG_STORE_MASK = 16'h3dd0;
  localparam logic [WORD_W-1:0] CFG_READ_MASK = 16'h1dd0;
  localparam logic [WORD_W-1:0] CFG_RESET = 16'h0000;

  // Twelve-bit data fields sit in bits 15:4 of the word.
  localparam int NUM_CH = 8;
  localparam int DATA_W = 12;
  localparam int DATA_LSB = 4;
  localparam logic [3:0] LOW_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
  localparam logic [DATA_W-1:0] ZERO_RESET = 12'h000;
  localparam logic [DATA_W-1:0] GAIN_RESET = 12'h800;
  localparam logic [DATA_W-1:0] DATA_MAX = 12'hfff;
  localparam int GAIN_SHIFT = 11;

  // Factory offset trims for span six and span four.
  localparam logic [DATA_W-1:0] TRIM_SPAN6 = 12'h99a;
  localparam logic [DATA_W-1:0] TRIM_SPAN4 = 12'haab;

  // Alternate wake allows at most this many clock falling edges.
  localparam logic [1:0] FALL_LIMIT = 2'h1;
  localparam logic [1:0] FALL_SAT = 2'h3;

endpackage : dac_cfg_pkg

// file: dac_config_control.sv
// Serial register interface and configuration control of an octal DAC.
`timescale 1ns/10ps
//
// How it works
// - A one written to the reset field resets the device like the reset pin.
// - The reset field clears itself when that reset has finished.
// - Group A power-down set to one parks channels 0-3 outputs.
// - Group A power-down at zero returns channels 0-3 to normal.
// - Group B power-down set to one parks channels 4-7 outputs.
// - Group B power-down at zero returns channels 4-7 to normal.
// - Serial interface keeps working while either group is powered down.
// - Calibration on: input corrected by gain and zero, then loaded.
// - Calibration off: input copied unchanged to data register, then loaded.
// - Reserved configuration bits ignore writes and read as zero.
// - Changing group A gain reloads group A offset with its factory trim.
// - Group A gain zero selects span six, one selects span four.
// - Changing group B gain reloads group B offset with its factory trim.
// - Group B gain zero selects span six, one selects span four.
// - Output-disable at one keeps serial output undriven, zero is normal.
// - No-effect bit does nothing, never stores, always reads zero.
// - Wake pin high and alternate wake on: select rise wakes from sleep.
// - More than one clock falling edge in the frame keeps it asleep.
// - Alternate wake off: select rise never wakes from sleep.
// - Wake pin low forces normal serial mode, alternate wake ignored.
// - In sleep, serial input passes straight to serial output.
// - Sleep bit clears on hardware reset and while wake pin is low.
module dac_config_control (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  input wire logic wake_pin_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  output logic group_a_powerdown_o,
  output logic group_b_powerdown_o,
  output logic span_four_a_o,
  output logic span_four_b_o,
  output logic calibration_enable_o,
  output logic serial_sleep_o,
  output logic [dac_cfg_pkg::DATA_W-1:0] offset_a_o,
  output logic [dac_cfg_pkg::DATA_W-1:0] offset_b_o,
  output logic [dac_cfg_pkg::NUM_CH*dac_cfg_pkg::DATA_W-1:0] dac_data_o,
  output logic [dac_cfg_pkg::NUM_CH-1:0] dac_load_o
);
  import dac_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Gain and zero correction with saturation to the code range.
  function automatic logic [DATA_W-1:0] calibrate(
    input logic [DATA_W-1:0] din,
    input logic [DATA_W-1:0] gain,
    input logic [DATA_W-1:0] zero
  );
    logic [2*DATA_W-1:0] prod;
    logic signed [DATA_W+2:0] sum;
    prod = {{DATA_W{1'b0}}, din} * {{DATA_W{1'b0}}, gain};
    sum = $signed({2'b00, prod[2*DATA_W-1:GAIN_SHIFT]})
        + $signed({{3{zero[DATA_W-1]}}, zero});
    if (sum[DATA_W+2]) begin
      calibrate = DATA_RESET;
    end else if (sum > $signed({3'b000, DATA_MAX})) begin
      calibrate = DATA_MAX;
    end else begin
      calibrate = sum[DATA_W-1:0];
    end
  endfunction : calibrate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic looks at a pin.
  logic cs_m_ff, cs_s_ff, cs_d_ff;
  logic sclk_m_ff, sclk_s_ff, sclk_d_ff;
  logic sdi_m_ff, sdi_s_ff;
  logic wake_m_ff, wake_s_ff;

  // Shift, count and readback state.
  logic [FRAME_BITS-1:0] rx_ff;
  logic [FRAME_BITS-1:0] tx_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  logic [1:0] fall_cnt_ff;
  logic [WORD_W-1:0] rd_word_ff;
  logic sdo_ff;
  logic sleep_ff;

  // Register file.
  logic [WORD_W-1:0] cfg_ff;
  logic [DATA_W-1:0] offset_a_ff, offset_b_ff;
  logic [DATA_W-1:0] in_ff [NUM_CH];
  logic [DATA_W-1:0] zero_ff [NUM_CH];
  logic [DATA_W-1:0] gain_ff [NUM_CH];
  logic [DATA_W-1:0] dac_ff [NUM_CH];
  logic [NUM_CH-1:0] load_ff;

  always_ff @(posedge clk_sys_i) begin
    cs_m_ff <= spi_cs_n_i;
    cs_s_ff <= cs_m_ff;
    cs_d_ff <= cs_s_ff;
    sclk_m_ff <= spi_sclk_i;
    sclk_s_ff <= sclk_m_ff;
    sclk_d_ff <= sclk_s_ff;
    sdi_m_ff <= spi_sdi_i;
    sdi_s_ff <= sdi_m_ff;
    wake_m_ff <= wake_pin_i;
    wake_s_ff <= wake_m_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and frame decode.
  wire cs_fall = cs_d_ff & ~cs_s_ff;
  wire cs_rise = ~cs_d_ff & cs_s_ff;
  wire cs_low = ~cs_s_ff;
  wire sclk_fall = cs_low & sclk_d_ff & ~sclk_s_ff;
  wire frame_ok = cs_rise & (bit_cnt_ff == FRAME_CNT) & ~sleep_ff;
  wire wr_hit = frame_ok & ~rx_ff[RW_POS];
  wire rd_hit = frame_ok & rx_ff[RW_POS];
  wire [ADDR_W-1:0] addr = rx_ff[ADDR_MSB:ADDR_LSB];
  wire [WORD_W-1:0] wdata = rx_ff[WORD_W-1:0];
  wire [DATA_W-1:0] wfield = wdata[WORD_W-1:DATA_LSB];
  wire [1:0] bank = addr[ADDR_W-1:ADDR_W-2];
  wire [2:0] ch = addr[2:0];
  wire wr_cfg = wr_hit & (addr == ADDR_CONFIG);
  wire wr_off_a = wr_hit & (addr == ADDR_OFFSET_A);
  wire wr_off_b = wr_hit & (addr == ADDR_OFFSET_B);
  wire wr_mode = wr_hit & (addr == ADDR_SPI_MODE);
  wire wr_in = wr_hit & (bank == BANK_INPUT);
  wire wr_zero = wr_hit & (bank == BANK_ZERO);
  wire wr_gain = wr_hit & (bank == BANK_GAIN);

  // Combined reset: pin reset or the self-clearing software reset.
  wire rst_all = srst_i | cfg_ff[SRST_POS];

  // New configuration word; reserved and no-effect bits never store.
  wire [WORD_W-1:0] nxt_cfg = wdata & CFG_STORE_MASK;
  wire gain_a_chg = wr_cfg & (nxt_cfg[GAINA_POS] != cfg_ff[GAINA_POS]);
  wire gain_b_chg = wr_cfg & (nxt_cfg[GAINB_POS] != cfg_ff[GAINB_POS]);
  wire [DATA_W-1:0] trim_a = nxt_cfg[GAINA_POS] ? TRIM_SPAN4 : TRIM_SPAN6;
  wire [DATA_W-1:0] trim_b = nxt_cfg[GAINB_POS] ? TRIM_SPAN4 : TRIM_SPAN6;

  // Value for the addressed channel's data register.
  wire [DATA_W-1:0] corrected = calibrate(wfield, gain_ff[ch], zero_ff[ch]);
  wire [DATA_W-1:0] nxt_dac =
    cfg_ff[CAL_POS] ? corrected : wfield;

  // Alternate wake decision at the select rising edge.
  wire alt_wake = cs_rise & sleep_ff & wake_s_ff & cfg_ff[ALTW_POS]
                & (fall_cnt_ff <= FALL_LIMIT);

  // Readback word selected by the address of a read frame.
  wire [WORD_W-1:0] rd_cfg = cfg_ff & CFG_READ_MASK;
  wire [WORD_W-1:0] rd_bank =
    (bank == BANK_INPUT) ? {in_ff[ch], LOW_ZERO} :
    (bank == BANK_ZERO) ? {zero_ff[ch], LOW_ZERO} :
    {gain_ff[ch], LOW_ZERO};
  wire [WORD_W-1:0] rd_mux =
    (addr == ADDR_CONFIG) ? rd_cfg :
    (addr == ADDR_OFFSET_A) ? {offset_a_ff, LOW_ZERO} :
    (addr == ADDR_OFFSET_B) ? {offset_b_ff, LOW_ZERO} :
    (bank != 2'h0) ? rd_bank : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Receive shift register and bit counter; runs whatever the power-down
  // state, so the interface stays live with groups parked.
  always_ff @(posedge clk_sys_i) begin
    if (rst_all || cs_fall) begin
      bit_cnt_ff <= '0;
      rx_ff <= '0;
    end else if (sclk_fall && !sleep_ff) begin
      rx_ff <= {rx_ff[FRAME_BITS-2:0], sdi_s_ff};
      if (bit_cnt_ff != FRAME_CNT) begin
        bit_cnt_ff <= bit_cnt_ff + CNT_W'(1);
      end else begin
        bit_cnt_ff <= FRAME_CNT + CNT_W'(1);
      end
    end
  end

  // Falling clock edges counted per select-low period, saturating.
  always_ff @(posedge clk_sys_i) begin
    if (rst_all || cs_fall) begin
      fall_cnt_ff <= '0;
    end else if (sclk_fall && fall_cnt_ff != FALL_SAT) begin
      fall_cnt_ff <= fall_cnt_ff + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep bit: set by a mode write, cleared by pin reset, wake pin low or
  // an allowed alternate wake. Software reset leaves it alone.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !wake_s_ff) begin
      sleep_ff <= 1'b0;
    end else if (alt_wake) begin
      sleep_ff <= 1'b0;
    end else if (wr_mode) begin
      sleep_ff <= wdata[SLEEP_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path: readback shifts out after each falling clock edge; in
  // sleep the input bit is passed straight through.
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      tx_ff <= '0;
      sdo_ff <= 1'b0;
      rd_word_ff <= '0;
    end else begin
      if (rd_hit) begin
        rd_word_ff <= rd_mux;
      end
      if (cs_fall) begin
        tx_ff <= {PAD_ZERO, rd_word_ff};
      end else if (sclk_fall) begin
        tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
      end
      sdo_ff <= sleep_ff ? sdi_s_ff : tx_ff[FRAME_BITS-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register; a written reset bit stays one for a single
  // cycle, during which rst_all returns everything to defaults.
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      cfg_ff <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Offset registers, reloaded with the trim when a gain bit changes.
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      offset_a_ff <= TRIM_SPAN6;
      offset_b_ff <= TRIM_SPAN6;
    end else begin
      if (gain_a_chg) begin
        offset_a_ff <= trim_a;
      end else if (wr_off_a) begin
        offset_a_ff <= wfield;
      end
      if (gain_b_chg) begin
        offset_b_ff <= trim_b;
      end else if (wr_off_b) begin
        offset_b_ff <= wfield;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel input, zero, gain and data registers, with a one-cycle load
  // pulse for the channel whose data register was written.
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_ff[i] <= DATA_RESET;
        zero_ff[i] <= ZERO_RESET;
        gain_ff[i] <= GAIN_RESET;
        dac_ff[i] <= DATA_RESET;
      end
      load_ff <= '0;
    end else begin
      load_ff <= '0;
      if (wr_in) begin
        in_ff[ch] <= wfield;
        dac_ff[ch] <= nxt_dac;
        load_ff[ch] <= 1'b1;
      end
      if (wr_zero) begin
        zero_ff[ch] <= wfield;
      end
      if (wr_gain) begin
        gain_ff[ch] <= wfield;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flatten the channel data registers onto the output bus.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      dac_data_o[i*DATA_W +: DATA_W] = dac_ff[i];
    end
  end

  // Output drivers; the serial output is released when disabled.
  assign spi_sdo_o = sdo_ff;
  assign spi_sdo_oe_n_o = cfg_ff[SDODIS_POS] | cs_s_ff;
  assign group_a_powerdown_o = cfg_ff[PDA_POS];
  assign group_b_powerdown_o = cfg_ff[PDB_POS];
  assign span_four_a_o = cfg_ff[GAINA_POS];
  assign span_four_b_o = cfg_ff[GAINB_POS];
  assign calibration_enable_o = cfg_ff[CAL_POS];
  assign serial_sleep_o = sleep_ff;
  assign offset_a_o = offset_a_ff;
  assign offset_b_o = offset_b_ff;
  assign dac_load_o = load_ff;

endmodule : dac_config_control

// file: dac_config_control_assertions.sv
// Concurrent checks on the ports of the DAC configuration block.
`timescale 1ns/10ps
module dac_config_control_assertions
  import dac_cfg_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  input wire logic wake_pin_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_n_o,
  input wire logic group_a_powerdown_o,
  input wire logic group_b_powerdown_o,
  input wire logic span_four_a_o,
  input wire logic span_four_b_o,
  input wire logic calibration_enable_o,
  input wire logic serial_sleep_o,
  input wire logic [dac_cfg_pkg::DATA_W-1:0] offset_a_o,
  input wire logic [dac_cfg_pkg::DATA_W-1:0] offset_b_o,
  input wire logic [dac_cfg_pkg::NUM_CH*dac_cfg_pkg::DATA_W-1:0] dac_data_o,
  input wire logic [dac_cfg_pkg::NUM_CH-1:0] dac_load_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  // Output control, reset values and offset reloads.
  sdo_release_a: assert property (
    spi_cs_n_i [*4] |-> spi_sdo_oe_n_o) else $error("sdo driven, cs high");
  reset_values_a: assert property (
    $fell(srst_i) |-> !group_a_powerdown_o && !group_b_powerdown_o &&
    !calibration_enable_o && !serial_sleep_o && offset_a_o == TRIM_SPAN6 &&
    offset_b_o == TRIM_SPAN6) else $error("reset values wrong");
  reload_a_a: assert property (
    $changed(span_four_a_o) |-> offset_a_o ==
    (span_four_a_o ? TRIM_SPAN4 : TRIM_SPAN6)) else $error("offset A trim");
  reload_b_a: assert property (
    $changed(span_four_b_o) |-> offset_b_o ==
    (span_four_b_o ? TRIM_SPAN4 : TRIM_SPAN6)) else $error("offset B trim");
  frame_gate_a: assert property (
    $changed(group_a_powerdown_o) || $changed(group_b_powerdown_o) |->
    $past(spi_cs_n_i) && $past(spi_cs_n_i, 3)) else $error("pd mid frame");
  ////////////////////////////////////////
  // Sleep behaviour and data loads.
  asleep_frozen_a: assert property (
    $past(serial_sleep_o) |-> $stable(calibration_enable_o) &&
    $stable(offset_a_o)) else $error("config changed asleep");
  mirror_a: assert property (
    (serial_sleep_o && $stable(spi_sdi_i)) [*5] |-> spi_sdo_o == spi_sdi_i)
    else $error("sdo not mirroring sdi");
  load_pulse_a: assert property (
    |dac_load_o |=> dac_load_o == '0) else $error("load pulse too long");
  load_gate_a: assert property (
    |dac_load_o |-> $past(spi_cs_n_i, 2) && !serial_sleep_o)
    else $error("load outside frame end");
  wake_cause_a: assert property (
    $fell(serial_sleep_o) |-> spi_cs_n_i || !wake_pin_i)
    else $error("wake without cause");
  wake_low_a: assert property (
    !wake_pin_i [*5] |-> !serial_sleep_o) else $error("asleep, pin low");
  cover property ($fell(serial_sleep_o) && wake_pin_i);
  cover property ($changed(span_four_a_o));
  cover property (|dac_load_o && calibration_enable_o);
endmodule : dac_config_control_assertions

bind dac_config_control dac_config_control_assertions chk_i (.clk_sys_i,
  .srst_i, .spi_cs_n_i, .spi_sclk_i, .spi_sdi_i, .wake_pin_i, .spi_sdo_o,
  .spi_sdo_oe_n_o, .group_a_powerdown_o, .group_b_powerdown_o,
  .span_four_a_o, .span_four_b_o, .calibration_enable_o, .serial_sleep_o,
  .offset_a_o, .offset_b_o, .dac_data_o, .dac_load_o);

// file: spi_host_model.sv
// Host serial master model that drives frames into the device.
`timescale 1ns/10ps
module spi_host_model (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  // Pins start idle: select high, clock low.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  ////////////////////////////////////////
  // Moves on a small fixed delay after a system clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : tick
  // One frame; a bit reads as z when the device does not drive.
  task automatic frame(input logic [23:0] w, output logic [23:0] r,
                       output logic drove);
    drove = 1'b0;
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 23; i >= 0; i--) begin
      sdi_o = w[i];
      sclk_o = 1'b1;
      tick(3);
      r[i] = sdo_oe_n_i ? 1'bz : sdo_i;
      drove = drove | !sdo_oe_n_i;
      tick(1);
      sclk_o = 1'b0;
      tick(4);
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;  // A released line shows the inverse of its last level.
    tick(8);
  endtask : frame
  // Holds select and data without clocking.
  task automatic hold(input logic c, input logic d, input int n);
    cs_n_o = c;
    sdi_o = d;
    tick(n);
  endtask : hold
  // Select pulse with a chosen count of clock falling edges.
  task automatic pulse(input int falls);
    cs_n_o = 1'b0;
    tick(4);
    repeat (falls) begin
      sclk_o = 1'b1;
      tick(4);
      sclk_o = 1'b0;
      tick(4);
    end
    cs_n_o = 1'b1;
    tick(8);
  endtask : pulse
endmodule : spi_host_model

// file: tb.sv
// Self-checking bench for the DAC configuration block.
`timescale 1ns/10ps
module tb;
  import dac_cfg_pkg::*;
  logic clk_sys_i, srst_i, wake_pin_i, cs_n, sclk, sdi, sdo, oe_n;
  logic pda, pdb, spa, spb, cal, sleep, drove;
  logic [DATA_W-1:0] offa, offb;
  logic [NUM_CH*DATA_W-1:0] data;
  logic [NUM_CH-1:0] load, last_load;
  logic [23:0] rx;
  logic [15:0] rv;
  int failures, checks_done;
  dac_config_control dac_config_control_i (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
    .wake_pin_i(wake_pin_i), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(oe_n),
    .group_a_powerdown_o(pda), .group_b_powerdown_o(pdb),
    .span_four_a_o(spa), .span_four_b_o(spb), .calibration_enable_o(cal),
    .serial_sleep_o(sleep), .offset_a_o(offa), .offset_b_o(offb),
    .dac_data_o(data), .dac_load_o(load));
  spi_host_model spi_host_model_i (.clk_sys_i(clk_sys_i), .sdo_i(sdo),
    .sdo_oe_n_i(oe_n), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  ////////////////////////////////////////
  // Clock, and a record of the last load pulse pattern.
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (|load) last_load <= load;
  // Compares a value seen with the one expected.
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    spi_host_model_i.frame({3'h0, a, d}, rx, drove);
  endtask : wr
  // A read answers in the following frame.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    spi_host_model_i.frame({3'h4, a, 16'h0000}, rx, drove);
    spi_host_model_i.frame({3'h4, 5'h01, 16'h0000}, rx, drove);
    d = rx[15:0];
  endtask : rd
  ////////////////////////////////////////
  // Field storage, read masking, power-down, gain and sdo disable.
  task automatic t_config;
    rd(ADDR_CONFIG, rv);
    chk("cfg rst", rv, 16'h0000);
    wr(ADDR_CONFIG, 16'hdfaf);
    rd(ADDR_CONFIG, rv);
    chk("cfg rd", rv, 16'h1d80);
    chk("pd", {pda, pdb, cal}, 16'h0007);
    chk("span", {spa, spb}, 16'h0003);
    chk("off a", offa, 16'h0aab);
    chk("off b", offb, 16'h0aab);
    wr(ADDR_CONFIG, 16'h1dc0);
    wr(ADDR_CONFIG, 16'h0000);
    chk("sdo off", drove, 16'h0000);
    rd(ADDR_CONFIG, rv);
    chk("sdo on", drove, 16'h0001);
    chk("pd off", {pda, pdb, spa, spb}, 16'h0000);
    chk("off b6", offb, 16'h099a);
  endtask : t_config
  // Offset reload only on a real gain change.
  task automatic t_gain;
    wr(ADDR_CONFIG, 16'h0100);
    wr(ADDR_OFFSET_A, 16'h1230);
    wr(ADDR_CONFIG, 16'h0100);
    chk("same gain", offa, 16'h0123);
    wr(ADDR_CONFIG, 16'h0000);
    chk("gain six", offa, 16'h099a);
  endtask : t_gain
  // Data path with correction off and on, then a software reset.
  task automatic t_cal;
    wr(5'h0a, 16'hab00);
    chk("raw", data[35:24], 16'h0ab0);
    chk("load", last_load, 16'h0004);
    wr(5'h12, 16'h0100);
    wr(ADDR_CONFIG, 16'h1c00);
    wr(5'h0a, 16'h1000);
    chk("corr", data[35:24], 16'h0110);
    wr(ADDR_CONFIG, 16'h2000);
    chk("srst", {pda, pdb, cal}, 16'h0000);
    chk("srst d", data[35:24], 16'h0000);
    rd(ADDR_CONFIG, rv);
    chk("srst bit", rv, 16'h0000);
    wr(ADDR_CONFIG, 16'h1000);
    chk("srst done", pda, 16'h0001);
  endtask : t_cal
  // Sleep pass-through and the ways out of sleep.
  task automatic t_sleep;
    wr(ADDR_SPI_MODE, 16'h8000);
    spi_host_model_i.hold(1'b0, 1'b1, 6);
    chk("mirror 1", sdo, 16'h0001);
    spi_host_model_i.hold(1'b0, 1'b0, 6);
    chk("mirror 0", sdo, 16'h0000);
    spi_host_model_i.hold(1'b1, 1'b0, 8);
    chk("no alt", sleep, 16'h0001);
    wake_pin_i = 1'b0;
    spi_host_model_i.tick(6);
    chk("pin low", sleep, 16'h0000);
    wake_pin_i = 1'b1;
    wr(ADDR_CONFIG, 16'h0010);
    wr(ADDR_SPI_MODE, 16'h8000);
    spi_host_model_i.pulse(2);
    chk("two falls", sleep, 16'h0001);
    spi_host_model_i.pulse(1);
    chk("one fall", sleep, 16'h0000);
    wr(ADDR_SPI_MODE, 16'h8000);
    chk("asleep", sleep, 16'h0001);
    srst_i = 1'b1;
    spi_host_model_i.tick(3);
    srst_i = 1'b0;
    spi_host_model_i.tick(2);
    chk("hw rst", sleep, 16'h0000);
    wake_pin_i = 1'b0;
    wr(ADDR_SPI_MODE, 16'h8000);
    chk("pin rules", sleep, 16'h0000);
    wake_pin_i = 1'b1;
  endtask : t_sleep
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  // Reset, run every scenario, then give the verdict.
  initial begin
    srst_i = 1'b1;
    wake_pin_i = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_sys_i);
    #2 srst_i = 1'b0;
    spi_host_model_i.tick(2);
    chk("off rst", offa, 16'h099a);
    t_config;
    t_gain;
    t_cal;
    t_sleep;
    stop_test;
  end
  // Cuts a hang short well after the expected run time.
  initial begin
    #1000000;
    failures++;
    stop_test;
  end
endmodule : tb
